/* rtl/line_if.sv */
// sampled two-wire line levels and start/stop events
`timescale 1ns/100ps
interface line_if;
  logic scl;
  logic sda;
  logic start_seen;
  logic stop_seen;
  modport sampler_mp (output scl, output sda, output start_seen, output stop_seen);
  modport engine_mp  (input scl, input sda, input start_seen, input stop_seen);
endinterface : line_if

/* rtl/line_sampler.sv */
// synchroniser and start/stop detector for the two bus lines
`timescale 1ns/100ps
module line_sampler (
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  input  wire logic  i_scl,
  input  wire logic  i_sda,
  line_if.sampler_mp lines
);

  logic scl_meta;
  logic scl_sync;
  logic sda_meta;
  logic sda_sync;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      scl_meta <= i_scl;
      scl_sync <= scl_meta;
      sda_meta <= i_sda;
      sda_sync <= sda_meta;
    end
  end

  // start: sda falls with scl high; stop: sda rises with scl high
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lines.scl        <= 1'b1;
      lines.sda        <= 1'b1;
      lines.start_seen <= 1'b0;
      lines.stop_seen  <= 1'b0;
    end else begin
      lines.scl        <= scl_sync;
      lines.sda        <= sda_sync;
      lines.start_seen <= scl_sync & lines.scl & lines.sda & ~sda_sync;
      lines.stop_seen  <= scl_sync & lines.scl & ~lines.sda & sda_sync;
    end
  end

endmodule : line_sampler

/* rtl/rate_timer.sv */
// half-period timer for scl, length set by the rate register
`timescale 1ns/100ps
`include "two_wire_consts.svh"
module rate_timer (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_clear,
  input  wire logic [7:0] i_rate,
  output logic            o_tick
);

  logic [8:0] count;
  logic [8:0] limit;

  assign limit = {1'b0, i_rate} + `HALF_BASE_CYC;

  always_ff @(posedge i_clk) begin
    if (i_rst || i_clear) begin
      count  <= 9'h000;
      o_tick <= 1'b0;
    end else if (count == limit) begin
      count  <= 9'h000;
      o_tick <= 1'b1;
    end else begin
      count  <= count + 9'h001;
      o_tick <= 1'b0;
    end
  end

endmodule : rate_timer

/* rtl/two_wire_consts.svh */
// register offsets, field positions, reset values and timing counts of the two-wire master
`ifndef TWO_WIRE_CONSTS_SVH
`define TWO_WIRE_CONSTS_SVH

`define OFF_CTRL_A      4'h3
`define OFF_CTRL_B      4'h4
`define OFF_STATUS      4'h5
`define OFF_RATE        4'h6
`define OFF_ADDR        4'h7
`define OFF_DATA        4'h8

`define CA_ENABLE       0
`define CB_ACKSEL       2
`define ST_RIF          7
`define ST_WIF          6
`define ST_HOLD         5
`define ST_ARB          3
`define ST_FAULT        2

`define CMD_REPSTART    2'h1
`define CMD_RECV        2'h2
`define CMD_STOP        2'h3

`define RATE_RESET      8'h00
`define ADDR_RESET      8'h00
`define DATA_RESET      8'h00

`define TX_BITS         4'h8
`define RX_BITS         4'h7
`define HALF_BASE_CYC   9'h005

`endif

/* rtl/two_wire_master_engine.sv */
// two-wire bus master: registers, bus condition tracking and byte sequencing
// Function
// R1 - bus condition field reports unknown, idle, owner, busy as codes 0 to 3
// R2 - bus condition is unknown after reset, on re-enable and while disabled
// R3 - writing idle code to bus condition forces idle; other codes ignored
// R4 - scl high and low times both come from the eight-bit rate value
// R5 - address write starts start-plus-address; address read has no bus effect
// R6 - address write with unknown bus sets write-complete and bus-fault, no bus drive
// R7 - busy bus: wait for idle, then start, copy address, send, sample ack
// R8 - address done sets write-complete; scl held low only when arbitration kept
// R9 - owned bus gives repeated start; after read, ack response goes first
// R10 - read address receives one data byte before read-complete is set
// R11 - address write clears all master flags
// R12 - address bit 0 is direction, one means read
// R13 - data register is the shift register; writes only while holding scl
// R14 - data write sends byte, samples ack, then always sets write-complete
// R15 - after losing arbitration all bits still clock, as ones
// R16 - data write clears both completion flags only
// R17 - data read sends ack selection, then receives one byte, sets read-complete
// R18 - lost nack or fault during read sets write-complete; never both flags
// R19 - data read clears both completion flags only
// R20 - software checks arbitration-lost after each write completion
// R21 - ack selection zero sends ack, one sends nack
// R22 - fault detection needs tracking enabled and clock four times scl
// R23 - scl is held low until software accesses data, address or command
`timescale 1ns/100ps
`include "two_wire_consts.svh"
module two_wire_master_engine (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rd_data,
  input  wire logic       i_scl,
  output logic            o_scl_out,
  output logic            o_scl_oe,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe
);

  logic [7:0]               scl_rate;
  logic [7:0]               target_address;
  logic [7:0]               shift_data;
  logic                     master_enable;
  logic                     enable_d;
  logic                     acknowledge_selection;
  logic                     read_complete_flag;
  logic                     write_complete_flag;
  logic                     bus_fault_flag;
  logic                     arbitration_lost_flag;
  logic                     rx_ack;
  logic [3:0]               bit_cnt;
  logic                     rx_mode;
  logic                     addr_phase;
  logic                     lost_in_byte;
  logic                     sda_want;
  logic                     tick;
  logic                     tmr_clear;
  two_wire_pkg::bus_cond_t  bus_condition_field;
  two_wire_pkg::seq_state_t state;
  two_wire_pkg::seq_state_t next_state;
  two_wire_pkg::seq_state_t prev_state;
  two_wire_pkg::after_ack_t pending_op;
  two_wire_pkg::after_ack_t next_op;

  logic       restart;
  logic       sw_addr;
  logic       sw_data_rd;
  logic       wr_data_ok;
  logic       wr_status;
  logic [1:0] cmd;
  logic       cmd_ok;
  logic       bit_end;
  logic       lost_now;
  logic       fault_now;
  logic       go_rx;
  logic       ev_wif;
  logic       ev_rif;
  logic       ev_fault;
  logic       ev_lost;

  line_if lines ();

  function automatic logic is_shifting(input two_wire_pkg::seq_state_t s);
    return (s == two_wire_pkg::S_BIT_LOW) || (s == two_wire_pkg::S_BIT_HIGH) ||
           (s == two_wire_pkg::S_ACK_LOW) || (s == two_wire_pkg::S_ACK_HIGH);
  endfunction : is_shifting

  function automatic logic is_high_phase(input two_wire_pkg::seq_state_t s);
    return (s == two_wire_pkg::S_BIT_HIGH) || (s == two_wire_pkg::S_ACK_HIGH) ||
           (s == two_wire_pkg::S_RS_HIGH)  || (s == two_wire_pkg::S_STOP_HIGH);
  endfunction : is_high_phase

  line_sampler u_sampler (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_scl (i_scl),
    .i_sda (i_sda),
    .lines (lines.sampler_mp)
  );

  // high phases restart counting while a slave stretches scl
  assign tmr_clear = (state != prev_state) || (is_high_phase(state) && !lines.scl);

  rate_timer u_timer (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_clear (tmr_clear),
    .i_rate  (scl_rate), // [R4]
    .o_tick  (tick)
  );

  assign restart    = master_enable && !enable_d;
  assign sw_addr    = i_wr && (i_addr == `OFF_ADDR);
  assign sw_data_rd = i_rd && (i_addr == `OFF_DATA);
  assign wr_status  = i_wr && (i_addr == `OFF_STATUS);
  assign wr_data_ok = i_wr && (i_addr == `OFF_DATA) && (state == two_wire_pkg::S_HOLD); // [R13]
  assign cmd        = (i_wr && (i_addr == `OFF_CTRL_B)) ? i_wr_data[1:0] : 2'h0;
  assign cmd_ok     = (state == two_wire_pkg::S_HOLD) && (cmd != 2'h0);
  assign bit_end    = (state == two_wire_pkg::S_BIT_HIGH) && tick;
  // a released data bit read back low means another master drove it
  assign lost_now   = bit_end && !rx_mode && (bit_cnt != 4'h0) && shift_data[7] &&
                      !lost_in_byte && !lines.sda;
  // only valid while the clock is at least four times scl
  assign fault_now  = master_enable && is_shifting(state) &&
                      (lines.start_seen || lines.stop_seen); // [R22]

  always_comb begin
    next_state = state;
    next_op    = pending_op;
    go_rx      = 1'b0;
    ev_wif     = 1'b0;
    ev_rif     = 1'b0;
    ev_fault   = 1'b0;
    ev_lost    = 1'b0;
    if (!master_enable || restart) begin
      next_state = two_wire_pkg::S_IDLE;
    end else if (fault_now) begin
      ev_fault   = 1'b1;
      ev_wif     = 1'b1; // [R18]
      next_state = two_wire_pkg::S_IDLE;
    end else begin
      case (state)
        two_wire_pkg::S_IDLE: begin
          if (sw_addr) begin // [R5]
            if (bus_condition_field == two_wire_pkg::BUS_UNKNOWN) begin
              ev_wif   = 1'b1; // [R6]
              ev_fault = 1'b1; // [R6]
            end else if (bus_condition_field == two_wire_pkg::BUS_IDLE) begin
              next_state = two_wire_pkg::S_START;
            end else begin
              next_state = two_wire_pkg::S_WAIT; // [R7]
            end
          end
        end
        two_wire_pkg::S_WAIT: begin
          if (bus_condition_field == two_wire_pkg::BUS_IDLE) begin
            next_state = two_wire_pkg::S_START; // [R7]
          end
        end
        two_wire_pkg::S_START: begin
          if (tick) begin
            next_state = two_wire_pkg::S_BIT_LOW;
          end
        end
        two_wire_pkg::S_RS_LOW: begin
          if (tick) begin
            next_state = two_wire_pkg::S_RS_HIGH;
          end
        end
        two_wire_pkg::S_RS_HIGH: begin
          if (tick && !lines.sda) begin
            ev_lost    = 1'b1;
            ev_wif     = 1'b1;
            next_state = two_wire_pkg::S_IDLE;
          end else if (tick) begin
            next_state = two_wire_pkg::S_START; // [R9]
          end
        end
        two_wire_pkg::S_BIT_LOW: begin
          if (tick) begin
            next_state = two_wire_pkg::S_BIT_HIGH;
          end
        end
        two_wire_pkg::S_BIT_HIGH: begin
          if (tick) begin
            if (bit_cnt != 4'h0) begin
              next_state = two_wire_pkg::S_BIT_LOW; // [R15]
            end else if (rx_mode) begin
              ev_rif     = 1'b1; // [R10] [R17]
              next_state = two_wire_pkg::S_HOLD;
            end else if (lost_in_byte) begin
              ev_wif     = 1'b1; // [R8] [R15]
              next_state = two_wire_pkg::S_IDLE;
            end else if (addr_phase && target_address[0] && !lines.sda) begin
              go_rx      = 1'b1; // [R10] [R12]
              next_state = two_wire_pkg::S_BIT_LOW;
            end else begin
              ev_wif     = 1'b1; // [R8] [R14]
              next_state = two_wire_pkg::S_HOLD;
            end
          end
        end
        two_wire_pkg::S_HOLD: begin
          // scl stays low here for as long as software leaves it [R23]
          if (sw_addr) begin
            next_op    = two_wire_pkg::OP_RS;
            next_state = rx_mode ? two_wire_pkg::S_ACK_LOW : two_wire_pkg::S_RS_LOW; // [R9]
          end else if (wr_data_ok) begin
            next_state = two_wire_pkg::S_BIT_LOW; // [R14]
          end else if (rx_mode && (sw_data_rd || cmd == `CMD_RECV)) begin
            next_op    = two_wire_pkg::OP_RX;
            next_state = two_wire_pkg::S_ACK_LOW; // [R17]
          end else if (cmd == `CMD_REPSTART) begin
            next_op    = two_wire_pkg::OP_RS;
            next_state = rx_mode ? two_wire_pkg::S_ACK_LOW : two_wire_pkg::S_RS_LOW;
          end else if (cmd == `CMD_STOP) begin
            next_op    = two_wire_pkg::OP_STOP;
            next_state = rx_mode ? two_wire_pkg::S_ACK_LOW : two_wire_pkg::S_STOP_LOW;
          end
        end
        two_wire_pkg::S_ACK_LOW: begin
          if (tick) begin
            next_state = two_wire_pkg::S_ACK_HIGH;
          end
        end
        two_wire_pkg::S_ACK_HIGH: begin
          if (tick && acknowledge_selection && !lines.sda) begin
            ev_lost    = 1'b1;
            ev_wif     = 1'b1; // [R18]
            next_state = two_wire_pkg::S_IDLE;
          end else if (tick) begin
            case (pending_op)
              two_wire_pkg::OP_RX: begin
                go_rx      = 1'b1;
                next_state = two_wire_pkg::S_BIT_LOW;
              end
              two_wire_pkg::OP_RS:   next_state = two_wire_pkg::S_RS_LOW;
              two_wire_pkg::OP_STOP: next_state = two_wire_pkg::S_STOP_LOW;
              default:               next_state = two_wire_pkg::S_HOLD;
            endcase
          end
        end
        two_wire_pkg::S_STOP_LOW: begin
          if (tick) begin
            next_state = two_wire_pkg::S_STOP_HIGH;
          end
        end
        two_wire_pkg::S_STOP_HIGH: begin
          if (tick) begin
            next_state = two_wire_pkg::S_IDLE;
          end
        end
        default: next_state = two_wire_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state      <= two_wire_pkg::S_IDLE;
      prev_state <= two_wire_pkg::S_IDLE;
      pending_op <= two_wire_pkg::OP_NONE;
      enable_d   <= 1'b0;
    end else begin
      state      <= next_state;
      prev_state <= state;
      pending_op <= next_op;
      enable_d   <= master_enable;
    end
  end

  // byte datapath; the shift register doubles as the data register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      shift_data   <= `DATA_RESET;
      bit_cnt      <= 4'h0;
      rx_mode      <= 1'b0;
      addr_phase   <= 1'b0;
      lost_in_byte <= 1'b0;
    end else if (state == two_wire_pkg::S_START && next_state == two_wire_pkg::S_BIT_LOW) begin
      shift_data   <= target_address; // [R7]
      bit_cnt      <= `TX_BITS;
      rx_mode      <= 1'b0;
      addr_phase   <= 1'b1;
      lost_in_byte <= 1'b0;
    end else if (wr_data_ok) begin
      shift_data   <= i_wr_data; // [R13]
      bit_cnt      <= `TX_BITS;
      rx_mode      <= 1'b0;
      addr_phase   <= 1'b0;
      lost_in_byte <= 1'b0;
    end else if (go_rx) begin
      bit_cnt      <= `RX_BITS;
      rx_mode      <= 1'b1;
      addr_phase   <= 1'b0;
    end else if (bit_end) begin
      if (rx_mode || bit_cnt != 4'h0) begin
        shift_data <= {shift_data[6:0], lines.sda};
      end
      if (lost_now) begin
        lost_in_byte <= 1'b1; // [R15]
      end
      if (bit_cnt != 4'h0) begin
        bit_cnt <= bit_cnt - 4'h1;
      end
    end
  end

  // hardware sets are applied last so they win over a same-cycle clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      read_complete_flag    <= 1'b0;
      write_complete_flag   <= 1'b0;
      bus_fault_flag        <= 1'b0;
      arbitration_lost_flag <= 1'b0;
      rx_ack                <= 1'b0;
    end else begin
      if (sw_addr) begin
        read_complete_flag    <= 1'b0; // [R11]
        write_complete_flag   <= 1'b0;
        bus_fault_flag        <= 1'b0;
        arbitration_lost_flag <= 1'b0;
      end
      if (wr_data_ok || cmd_ok || (sw_data_rd && state == two_wire_pkg::S_HOLD)) begin
        read_complete_flag  <= 1'b0; // [R16] [R19]
        write_complete_flag <= 1'b0;
      end
      if (wr_status) begin
        if (i_wr_data[`ST_RIF])   read_complete_flag    <= 1'b0;
        if (i_wr_data[`ST_WIF])   write_complete_flag   <= 1'b0;
        if (i_wr_data[`ST_ARB])   arbitration_lost_flag <= 1'b0;
        if (i_wr_data[`ST_FAULT]) bus_fault_flag        <= 1'b0;
      end
      if (ev_wif) write_complete_flag <= 1'b1;
      if (ev_rif) read_complete_flag  <= 1'b1;
      if (ev_fault) bus_fault_flag <= 1'b1;
      if (ev_lost || lost_now) arbitration_lost_flag <= 1'b1;
      if (bit_end && !rx_mode && bit_cnt == 4'h0) begin
        rx_ack <= lines.sda;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bus_condition_field <= two_wire_pkg::BUS_UNKNOWN; // [R2]
    end else if (!master_enable || restart) begin
      bus_condition_field <= two_wire_pkg::BUS_UNKNOWN; // [R2]
    end else if (wr_status && i_wr_data[1:0] == two_wire_pkg::BUS_IDLE) begin
      bus_condition_field <= two_wire_pkg::BUS_IDLE; // [R3]
    end else if (state == two_wire_pkg::S_START) begin
      bus_condition_field <= two_wire_pkg::BUS_OWNER; // [R1]
    end else if (ev_lost || lost_now) begin
      bus_condition_field <= two_wire_pkg::BUS_BUSY;
    end else if (lines.stop_seen) begin
      bus_condition_field <= two_wire_pkg::BUS_IDLE;
    end else if (lines.start_seen) begin
      bus_condition_field <= two_wire_pkg::BUS_BUSY;
    end
  end

  // rate should only change while disabled; nothing here enforces it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      master_enable         <= 1'b0;
      acknowledge_selection <= 1'b0;
      scl_rate              <= `RATE_RESET;
      target_address        <= `ADDR_RESET;
    end else if (i_wr) begin
      case (i_addr)
        `OFF_CTRL_A: master_enable         <= i_wr_data[`CA_ENABLE];
        `OFF_CTRL_B: acknowledge_selection <= i_wr_data[`CB_ACKSEL]; // [R21]
        `OFF_RATE:   scl_rate              <= i_wr_data; // [R4]
        `OFF_ADDR:   target_address        <= i_wr_data;
        default:     ;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rd_data <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `OFF_CTRL_A: o_rd_data <= {7'h00, master_enable};
        `OFF_CTRL_B: o_rd_data <= {5'h00, acknowledge_selection, 2'h0};
        `OFF_STATUS: o_rd_data <= {read_complete_flag, write_complete_flag,
                                   state == two_wire_pkg::S_HOLD, rx_ack,
                                   arbitration_lost_flag, bus_fault_flag,
                                   (master_enable ? bus_condition_field :
                                    two_wire_pkg::BUS_UNKNOWN)}; // [R1] [R2] [R8]
        `OFF_RATE:   o_rd_data <= scl_rate;
        `OFF_ADDR:   o_rd_data <= target_address; // [R5]
        `OFF_DATA:   o_rd_data <= shift_data;
        default:     o_rd_data <= 8'h00;
      endcase
    end else begin
      o_rd_data <= 8'h00;
    end
  end

  // sda lags scl by a cycle so data never moves on a clock edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
      o_scl_oe  <= 1'b0;
      sda_want  <= 1'b0;
      o_sda_oe  <= 1'b0;
    end else begin
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
      o_scl_oe  <= master_enable &&
                   (state == two_wire_pkg::S_BIT_LOW || state == two_wire_pkg::S_ACK_LOW ||
                    state == two_wire_pkg::S_RS_LOW  || state == two_wire_pkg::S_STOP_LOW ||
                    state == two_wire_pkg::S_HOLD); // [R8] [R23]
      sda_want  <= master_enable &&
                   (state == two_wire_pkg::S_START || state == two_wire_pkg::S_STOP_LOW ||
                    state == two_wire_pkg::S_STOP_HIGH ||
                    ((state == two_wire_pkg::S_BIT_LOW || state == two_wire_pkg::S_BIT_HIGH) &&
                     !rx_mode && bit_cnt != 4'h0 && !shift_data[7] && !lost_in_byte) || // [R15]
                    ((state == two_wire_pkg::S_ACK_LOW || state == two_wire_pkg::S_ACK_HIGH) &&
                     !acknowledge_selection)); // [R21]
      o_sda_oe  <= sda_want;
    end
  end

endmodule : two_wire_master_engine

/* rtl/two_wire_pkg.sv */
// types shared by the two-wire master engine
package two_wire_pkg;

  typedef enum logic [1:0] {
    BUS_UNKNOWN = 2'h0,
    BUS_IDLE    = 2'h1,
    BUS_OWNER   = 2'h2,
    BUS_BUSY    = 2'h3
  } bus_cond_t;

  typedef enum logic [11:0] {
    S_IDLE      = 12'h001,
    S_WAIT      = 12'h002,
    S_START     = 12'h004,
    S_RS_LOW    = 12'h008,
    S_RS_HIGH   = 12'h010,
    S_BIT_LOW   = 12'h020,
    S_BIT_HIGH  = 12'h040,
    S_HOLD      = 12'h080,
    S_ACK_LOW   = 12'h100,
    S_ACK_HIGH  = 12'h200,
    S_STOP_LOW  = 12'h400,
    S_STOP_HIGH = 12'h800
  } seq_state_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_RX   = 2'h1,
    OP_RS   = 2'h2,
    OP_STOP = 2'h3
  } after_ack_t;

endpackage : two_wire_pkg

/* verif/test_two_wire_master_engine.sv */
// self-checking bench for the two-wire master engine with a behavioural slave
`timescale 1ns/100ps
module test_two_wire_master_engine;
  logic       i_clk;
  logic       i_rst;
  logic       i_wr;
  logic       i_rd;
  logic [3:0] i_addr;
  logic [7:0] i_wr_data;
  logic [7:0] o_rd_data;
  logic [7:0] v;
  logic [7:0] s;
  logic       o_scl_oe;
  logic       o_sda_oe;
  logic       slv_oe;
  int         miscompares;
  int         n_checks;
  // open-drain lines: low while any party drives, pulled high otherwise
  wire scl = !(o_scl_oe === 1'b1);
  wire sda = !(o_sda_oe === 1'b1 || slv_oe === 1'b1);
  two_wire_master_engine u_two_wire_master_engine (.i_clk(i_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .i_scl(scl), .o_scl_out(), .o_scl_oe(o_scl_oe), .i_sda(sda), .o_sda_out(),
    .o_sda_oe(o_sda_oe));
  two_wire_slave_model u_two_wire_slave_model (.i_scl(scl), .i_sda(sda), .o_sda_oe(slv_oe));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic give_verdict;
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // one access then a status read at once; v and s take the two answers
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    i_addr <= 4'h5;
    #1 v = o_rd_data;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 s = o_rd_data;
    @(posedge i_clk);
  endtask : acc
  task automatic wait_st(input logic [7:0] m, input logic [7:0] e);
    for (int k = 0; k < 300; k++) begin
      acc(1'b0, 4'h5, 8'h00);
      if ((s & m) === e) return;
    end
    chk("status_wait", e, s & m);
    give_verdict();
  endtask : wait_st
  task automatic t_reset;
    for (int k = 5; k < 9; k++) begin
      acc(1'b0, k[3:0], 8'h00);
      chk("reset_value", 8'h00, v);
    end
  endtask : t_reset
  task automatic t_unknown;
    acc(1'b1, 4'h6, 8'h02);
    acc(1'b1, 4'h3, 8'h01);
    chk("bus_enabled", 8'h00, s & 8'h03);
    acc(1'b1, 4'h7, 8'ha0);
    wait_st(8'h44, 8'h44);
    chk("status_unknown", 8'h44, s);
    acc(1'b1, 4'h5, 8'h03);
    chk("status_no_force", 8'h44, s);
    acc(1'b1, 4'h5, 8'h01);
    chk("status_idle", 8'h45, s);
  endtask : t_unknown
  task automatic t_write;
    acc(1'b1, 4'h7, 8'ha0);
    chk("flags_addr", 8'h00, s & 8'hcc);
    wait_st(8'h40, 8'h40);
    chk("status_addr", 8'h62, s);
    chk("slave_addr", 8'ha0, u_two_wire_slave_model.last);
    acc(1'b1, 4'h8, 8'h3c);
    chk("flags_data", 8'h00, s & 8'hc0);
    wait_st(8'h40, 8'h40);
    chk("status_data", 8'h62, s);
    chk("slave_data", 8'h3c, u_two_wire_slave_model.last);
  endtask : t_write
  task automatic t_read;
    acc(1'b1, 4'h7, 8'ha1);
    wait_st(8'h80, 8'h80);
    chk("status_rx", 8'ha2, s);
    acc(1'b0, 4'h8, 8'h00);
    chk("rx_byte", 8'h5a, v);
    chk("flags_read", 8'h00, s & 8'hc0);
    wait_st(8'h80, 8'h80);
    chk("status_rx2", 8'ha2, s);
    chk("ack_bit", 8'h00, {7'h00, u_two_wire_slave_model.ack_seen});
    acc(1'b1, 4'h4, 8'h07);
    wait_st(8'h03, 8'h01);
    chk("nack_bit", 8'h01, {7'h00, u_two_wire_slave_model.ack_seen});
    acc(1'b0, 4'h7, 8'h00);
    chk("addr_readback", 8'ha1, v);
    acc(1'b1, 4'h3, 8'h00);
    chk("bus_disabled", 8'h00, s & 8'h03);
  endtask : t_read
  initial begin
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wr_data = 8'h00;
    miscompares = 0;
    n_checks = 0;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_reset();
    t_unknown();
    t_write();
    t_read();
    give_verdict();
  end
endmodule : test_two_wire_master_engine

/* verif/two_wire_master_engine_assertions.sv */
// checker for the two-wire master engine register and line ports
`timescale 1ns/100ps
module two_wire_master_engine_checker (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rd_data,
  input wire logic       o_scl_oe,
  input wire logic       o_sda_oe
);
  logic       en;
  logic       scl_q;
  logic [7:0] rate;
  logic [8:0] run;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  always_ff @(posedge i_clk) begin
    if (i_rst) en <= 1'b0;
    else if (i_wr && i_addr == 4'h3) en <= i_wr_data[0];
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) rate <= 8'h00;
    else if (i_wr && i_addr == 4'h6) rate <= i_wr_data;
  end
  // cycles at the present scl level, saturating so a long hold never wraps
  always_ff @(posedge i_clk) begin
    scl_q <= o_scl_oe;
    run   <= (i_rst || o_scl_oe != scl_q) ? 9'h000 : run + {8'h00, ~&run};
  end
  sequence rd_status;
    i_rd && i_addr == 4'h5;
  endsequence
  AST_OFF_UNKNOWN: assert property (i_wr && i_addr == 4'h3 && !(en && i_wr_data[0])
    ##1 rd_status |=> o_rd_data[1:0] == 2'h0) else $error("bus condition not unknown");
  AST_FORCE_IDLE: assert property (en && i_wr && i_addr == 4'h5 && i_wr_data[1:0] == 2'h1
    ##1 rd_status |=> o_rd_data[1:0] == 2'h1) else $error("idle code did not force idle");
  AST_HALF_TIME: assert property (o_scl_oe != scl_q |-> run >= {1'b0, rate} + 9'h005)
    else $error("scl half period too short");
  AST_OFF_NO_DRIVE: assert property (!en [*3] |-> !o_scl_oe && !o_sda_oe)
    else $error("lines driven while disabled");
  AST_ADDR_CLEARS: assert property (i_wr && i_addr == 4'h7 ##1 rd_status
    |=> o_rd_data[1:0] == 2'h0 || (o_rd_data & 8'hcc) == 8'h00) else $error("flags kept");
  AST_DATA_WR_CLEARS: assert property (i_wr && i_addr == 4'h8 ##1 rd_status
    |=> o_rd_data[7:6] == 2'h0) else $error("flags kept after data write");
  AST_DATA_RD_CLEARS: assert property (i_rd && i_addr == 4'h8 ##1 rd_status
    |=> o_rd_data[7:6] == 2'h0) else $error("flags kept after data read");
  AST_FLAGS_APART: assert property (rd_status |=> !(o_rd_data[7] && o_rd_data[6]))
    else $error("both completion flags set");
endmodule : two_wire_master_engine_checker
bind two_wire_master_engine two_wire_master_engine_checker u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
  .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe));

/* verif/two_wire_slave_model.sv */
// behavioural slave: acks every byte it receives, serves a fixed byte when read
`timescale 1ns/100ps
module two_wire_slave_model #(
  parameter logic [7:0] RD_BYTE = 8'h5a
) (
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_oe = 1'b0
);
  logic [3:0] cnt      = 4'h0;
  logic [7:0] sh       = 8'h00;
  logic [7:0] last     = 8'h00;
  logic       rd       = 1'b0;
  logic       first    = 1'b0;
  logic       ack_seen = 1'b0;
  // start or stop: sda moves while scl is high
  always @(i_sda) begin
    if (i_scl) begin
      cnt = 4'h0;
      rd = 1'b0;
      first = !i_sda;
      o_sda_oe = 1'b0;
    end
  end
  always @(posedge i_scl) begin
    if (cnt < 4'h8) sh = {sh[6:0], i_sda};
    if (cnt == 4'h7) last = sh;
    if (cnt == 4'h8) begin
      ack_seen = i_sda;
      // a nack ends the read so the master can issue stop
      if (i_sda) rd = 1'b0;
    end
    cnt = cnt + 4'h1;
  end
  always @(negedge i_scl) begin
    if (cnt == 4'h9) begin
      cnt = 4'h0;
      if (first) rd = sh[0];
      first = 1'b0;
    end
    if (rd) o_sda_oe = (cnt < 4'h8) && !RD_BYTE[~cnt[2:0]];
    else o_sda_oe = (cnt == 4'h8);
  end
endmodule : two_wire_slave_model
